//--- src/tpg_test_pattern.v
// Functional notes
// - test mode replaces converted data at formatter
// - four-bit selector; shorts at codes one-three
// - only some patterns pass the formatter
// - control bits four/five reseed pseudorandom generators
// - analog sample ignored during any test
// - code 0100 alternates 0x1555 and 0x2AAA
// - code 0101 long generator, x23+x18+1
// - code 0110 short generator, x9+x5+1
// - code 0111 toggles all zeros, all ones
// - code 1000 repeat cycles four user words
// - code 1000 single: four words, then zeros
// - formatter: offset binary, twos complement, Gray

`default_nettype none

module tpg_test_pattern #(
  parameter DATA_W = 14
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [DATA_W-1:0] adc_data,
  input wire sclk,
  input wire spi_cs_n,
  input wire sdio_in,
  output wire sdio_out,
  output wire sdio_oe,
  output reg [DATA_W-1:0] dout_q,
  output reg test_active_q
);

`include "tpg_defs.vh"

////////////////////////////////////////////////////////////////////////
// helpers

// formatter; input word is twos complement
function [13:0] fmt_word;
  input [13:0] w;
  input [1:0] sel;
  reg [13:0] ob;
  begin
    ob = {~w[13], w[12:0]};
    case (sel)
      `TPG_FMT_OFFSET: fmt_word = ob;
      `TPG_FMT_GRAY: fmt_word = ob ^ {1'b0, ob[13:1]};
      default: fmt_word = w;
    endcase
  end
endfunction

// fourteen steps of a Fibonacci register; returns {word, state}
function [36:0] pn_step;
  input [22:0] s;
  input integer len;
  input integer tap;
  reg [22:0] st;
  reg [22:0] mask;
  reg [13:0] w;
  reg fb;
  integer i;
  begin
    st = s;
    mask = ~(23'h7FFFFF << len);
    w = 14'h0000;
    for (i = 0; i < 14; i = i + 1) begin
      fb = st[len-1] ^ st[tap-1];
      st = {st[21:0], fb} & mask;
      w = {w[12:0], fb};
    end
    pn_step = {w, st};
  end
endfunction

// register decode, shared by the read mux and the write port
localparam DEC_NONE = 2'h0;
localparam DEC_MODE = 2'h1;
localparam DEC_USER = 2'h2;
localparam DEC_FMT = 2'h3;

function [1:0] reg_decode;
  input [14:0] a;
  begin
    if (a == `TPG_OFS_MODE_CTL) begin
      reg_decode = DEC_MODE;
    end else if (a >= `TPG_OFS_USER_FIRST && a <= `TPG_OFS_USER_LAST) begin
      reg_decode = DEC_USER;
    end else if (a == `TPG_OFS_OUT_FMT) begin
      reg_decode = DEC_FMT;
    end else begin
      reg_decode = DEC_NONE;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// register file

reg [7:0] mode_ctl_q;
reg [7:0] out_fmt_q;
reg [7:0] user_q [0:7];
wire [14:0] reg_addr;
wire reg_wr;
wire [7:0] reg_wdata;
reg [7:0] reg_rdata;
wire [14:0] user_off;
wire [1:0] reg_dec;
integer k;

assign user_off = reg_addr - `TPG_OFS_USER_FIRST;
assign reg_dec = reg_decode(reg_addr);

tpg_spi_port u_spi (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .sclk(sclk),
  .cs_n(spi_cs_n),
  .sdi(sdio_in),
  .rdata(reg_rdata),
  .addr_q(reg_addr),
  .wr_stb_q(reg_wr),
  .wdata_q(reg_wdata),
  .sdo_q(sdio_out),
  .sdo_oe_q(sdio_oe)
);

always @* begin
  if (reg_dec == DEC_MODE) begin
    reg_rdata = mode_ctl_q;
  end else if (reg_dec == DEC_USER) begin
    reg_rdata = user_q[user_off[2:0]];
  end else if (reg_dec == DEC_FMT) begin
    reg_rdata = out_fmt_q;
  end else begin
    reg_rdata = 8'h00;
  end
end

always @(posedge clk) begin
  if (rst) begin
    mode_ctl_q <= `TPG_MODE_CTL_RST;
    out_fmt_q <= `TPG_OUT_FMT_RST;
    for (k = 0; k < 8; k = k + 1) begin
      user_q[k] <= `TPG_USER_RST;
    end
  end else if (ce && reg_wr) begin
    // unmapped writes are dropped
    if (reg_dec == DEC_MODE) begin
      mode_ctl_q <= reg_wdata;
    end else if (reg_dec == DEC_USER) begin
      user_q[user_off[2:0]] <= reg_wdata;
    end else if (reg_dec == DEC_FMT) begin
      out_fmt_q <= {6'h00, reg_wdata[1:0]};
    end
  end
end

////////////////////////////////////////////////////////////////////////
// pattern sequencing state

wire [3:0] tmode;
wire single_mode;
wire pn_long_rst;
wire pn_short_rst;
reg [3:0] prev_mode_q;
reg phase_q;
reg [1:0] uidx_q;
reg udone_q;
reg [13:0] ramp_q;
reg [22:0] pn_long_q;
reg [22:0] pn_short_q;
wire mode_chg;
wire eff_phase;
wire [1:0] eff_uidx;
wire eff_udone;
wire [13:0] eff_ramp;
wire [36:0] pn_long_nx;
wire [36:0] pn_short_nx;
wire [15:0] user_word;

assign tmode = mode_ctl_q[`TPG_MODE_MSB:`TPG_MODE_LSB];
assign single_mode = mode_ctl_q[`TPG_BIT_USER_SINGLE];
assign pn_long_rst = mode_ctl_q[`TPG_BIT_PN_LONG_RST];
assign pn_short_rst = mode_ctl_q[`TPG_BIT_PN_SHORT_RST];

// a fresh selection starts the checkerboard, toggle, user and ramp sequences from their first word; the generators resume
assign mode_chg = tmode != prev_mode_q;
assign eff_phase = mode_chg ? 1'b0 : phase_q;
assign eff_uidx = mode_chg ? 2'h0 : uidx_q;
assign eff_udone = mode_chg ? 1'b0 : udone_q;
assign eff_ramp = mode_chg ? 14'h0000 : ramp_q;

assign pn_long_nx = pn_step(pn_long_q, `TPG_PN_LONG_LEN, `TPG_PN_LONG_TAP);
assign pn_short_nx = pn_step(pn_short_q, `TPG_PN_SHORT_LEN, `TPG_PN_SHORT_TAP);

assign user_word = {user_q[{eff_uidx, 1'b1}], user_q[{eff_uidx, 1'b0}]};

// advance per sample: nothing moves without the sample clock and enable
always @(posedge clk) begin
  if (rst) begin
    prev_mode_q <= `TPG_TM_OFF;
    phase_q <= 1'b0;
    uidx_q <= 2'h0;
    udone_q <= 1'b0;
    ramp_q <= 14'h0000;
    pn_long_q <= `TPG_PN_LONG_SEED;
    pn_short_q <= `TPG_PN_SHORT_SEED;
  end else if (ce) begin
    prev_mode_q <= tmode;
    phase_q <= ~eff_phase;
    ramp_q <= eff_ramp + 14'h0001;
    uidx_q <= eff_uidx + 2'h1;
    udone_q <= eff_udone | (single_mode && eff_uidx == 2'h3);
    if (pn_long_rst) begin
      pn_long_q <= `TPG_PN_LONG_SEED;
    end else if (tmode == `TPG_TM_PN_LONG) begin
      pn_long_q <= pn_long_nx[22:0];
    end
    if (pn_short_rst) begin
      pn_short_q <= `TPG_PN_SHORT_SEED;
    end else if (tmode == `TPG_TM_PN_SHORT) begin
      pn_short_q <= pn_short_nx[22:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// output selection

reg [13:0] word_d;
wire [1:0] fmt_sel;

assign fmt_sel = out_fmt_q[1:0];

always @* begin
  case (tmode)
    `TPG_TM_OFF: begin
      word_d = fmt_word(adc_data, fmt_sel);
    end
    `TPG_TM_MIDSCALE: begin
      word_d = fmt_word(`TPG_W_MIDSCALE, fmt_sel);
    end
    `TPG_TM_POS_FS: begin
      word_d = fmt_word(`TPG_W_POS_FS, fmt_sel);
    end
    `TPG_TM_NEG_FS: begin
      word_d = fmt_word(`TPG_W_NEG_FS, fmt_sel);
    end
    `TPG_TM_CHECKER: begin
      word_d = eff_phase ? `TPG_W_CHECK_B : `TPG_W_CHECK_A;
    end
    `TPG_TM_PN_LONG: begin
      word_d = pn_long_nx[36:23];
    end
    `TPG_TM_PN_SHORT: begin
      word_d = pn_short_nx[36:23];
    end
    `TPG_TM_TOGGLE: begin
      word_d = eff_phase ? `TPG_W_ONES : `TPG_W_ZEROS;
    end
    `TPG_TM_USER: begin
      // user word bits 15 to 2
      word_d = eff_udone ? `TPG_W_ZEROS : user_word[15:2];
    end
    `TPG_TM_RAMP: begin
      word_d = eff_ramp;
    end
    default: begin
      word_d = `TPG_W_ZEROS;
    end
  endcase
end

always @(posedge clk) begin
  if (rst) begin
    dout_q <= {DATA_W{1'b0}};
    test_active_q <= 1'b0;
  end else if (ce) begin
    dout_q <= word_d;
    test_active_q <= tmode != `TPG_TM_OFF;
  end
end

endmodule // tpg_test_pattern

`default_nettype wire

//--- src/tpg_defs.vh
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH

// register offsets on the serial configuration port
`define TPG_ADDR_W 15
`define TPG_OFS_MODE_CTL 15'h0550
`define TPG_OFS_USER_FIRST 15'h0551
`define TPG_OFS_USER_LAST 15'h0558
`define TPG_OFS_OUT_FMT 15'h0561

// reset values
`define TPG_MODE_CTL_RST 8'h00
`define TPG_OUT_FMT_RST 8'h01
`define TPG_USER_RST 8'h00

// field positions in the test mode control register
`define TPG_MODE_LSB 0
`define TPG_MODE_MSB 3
`define TPG_BIT_PN_LONG_RST 4
`define TPG_BIT_PN_SHORT_RST 5
`define TPG_BIT_USER_SINGLE 7

// test mode selector codes
`define TPG_TM_OFF 4'h0
`define TPG_TM_MIDSCALE 4'h1
`define TPG_TM_POS_FS 4'h2
`define TPG_TM_NEG_FS 4'h3
`define TPG_TM_CHECKER 4'h4
`define TPG_TM_PN_LONG 4'h5
`define TPG_TM_PN_SHORT 4'h6
`define TPG_TM_TOGGLE 4'h7
`define TPG_TM_USER 4'h8
`define TPG_TM_RAMP 4'hF

// output format selector codes
`define TPG_FMT_OFFSET 2'h0
`define TPG_FMT_TWOS 2'h1
`define TPG_FMT_GRAY 2'h2

// fixed pattern words, twos complement
`define TPG_W_MIDSCALE 14'h0000
`define TPG_W_POS_FS 14'h1FFF
`define TPG_W_NEG_FS 14'h2000
`define TPG_W_CHECK_A 14'h1555
`define TPG_W_CHECK_B 14'h2AAA
`define TPG_W_ZEROS 14'h0000
`define TPG_W_ONES 14'h3FFF

// pseudorandom generators
`define TPG_PN_LONG_SEED 23'h003AFF
`define TPG_PN_LONG_LEN 23
`define TPG_PN_LONG_TAP 18
`define TPG_PN_SHORT_SEED 23'h000092
`define TPG_PN_SHORT_LEN 9
`define TPG_PN_SHORT_TAP 5

// serial port framing
`define TPG_SPI_HDR_LAST 5'h0F
`define TPG_SPI_BYTE_LAST 5'h07

`endif

//--- src/tpg_spi_port.v
`default_nettype none

module tpg_spi_port (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  input wire [7:0] rdata,
  output reg [14:0] addr_q,
  output reg wr_stb_q,
  output reg [7:0] wdata_q,
  output reg sdo_q,
  output reg sdo_oe_q
);

`include "tpg_defs.vh"

reg [2:0] sclk_s_q;
reg [2:0] cs_s_q;
reg [2:0] sdi_s_q;
reg sclk_lvl_q;
reg active_q;
reg [15:0] sh_in_q;
reg [7:0] sh_out_q;
reg [4:0] cnt_q;
reg hdr_q;
reg rd_q;
reg inc_q;
wire rise;
wire fall;
wire bit_in;

////////////////////////////////////////////////////////////////////////
// three-stage synchronisers; edges only counted once stages 2 and 3 agree
// a one-flop glitch on the serial clock never reaches the shifter
assign rise = sclk_s_q[1] & sclk_s_q[2] & ~sclk_lvl_q;
assign fall = ~sclk_s_q[1] & ~sclk_s_q[2] & sclk_lvl_q;
assign bit_in = sdi_s_q[2];

always @(posedge clk) begin
  if (rst) begin
    sclk_s_q <= 3'h0;
    cs_s_q <= 3'h7;
    sdi_s_q <= 3'h0;
    sclk_lvl_q <= 1'b0;
    active_q <= 1'b0;
  end else if (ce) begin
    sclk_s_q <= {sclk_s_q[1:0], sclk};
    cs_s_q <= {cs_s_q[1:0], cs_n};
    sdi_s_q <= {sdi_s_q[1:0], sdi};
    if (sclk_s_q[1] == sclk_s_q[2]) begin
      sclk_lvl_q <= sclk_s_q[2];
    end
    if (cs_s_q[1] == cs_s_q[2]) begin
      active_q <= ~cs_s_q[1];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// 16-bit instruction (read flag, address), then streamed data bytes
always @(posedge clk) begin
  if (rst) begin
    sh_in_q <= 16'h0000;
    sh_out_q <= 8'h00;
    cnt_q <= 5'h00;
    hdr_q <= 1'b0;
    rd_q <= 1'b0;
    inc_q <= 1'b0;
    addr_q <= 15'h0000;
    wr_stb_q <= 1'b0;
    wdata_q <= 8'h00;
    sdo_q <= 1'b0;
    sdo_oe_q <= 1'b0;
  end else if (ce) begin
    wr_stb_q <= 1'b0;
    inc_q <= 1'b0;
    // address moves one cycle after the byte so a write strobe sees the old one
    if (inc_q) begin
      addr_q <= addr_q + 15'h0001;
    end
    if (!active_q) begin
      cnt_q <= 5'h00;
      hdr_q <= 1'b0;
      rd_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (rise) begin
      sh_in_q <= {sh_in_q[14:0], bit_in};
      if (!hdr_q) begin
        if (cnt_q == `TPG_SPI_HDR_LAST) begin
          hdr_q <= 1'b1;
          rd_q <= sh_in_q[14];
          addr_q <= {sh_in_q[13:0], bit_in};
          cnt_q <= 5'h00;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end else if (cnt_q == `TPG_SPI_BYTE_LAST) begin
        cnt_q <= 5'h00;
        inc_q <= 1'b1;
        wr_stb_q <= ~rd_q;
        wdata_q <= {sh_in_q[6:0], bit_in};
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end else if (fall && hdr_q && rd_q) begin
      // read data leaves on falling edges, most significant bit first
      sdo_oe_q <= 1'b1;
      if (cnt_q == 5'h00) begin
        sdo_q <= rdata[7];
        sh_out_q <= {rdata[6:0], 1'b0};
      end else begin
        sdo_q <= sh_out_q[7];
        sh_out_q <= {sh_out_q[6:0], 1'b0};
      end
    end
  end
end

endmodule // tpg_spi_port

`default_nettype wire

//--- tb/tpg_test_pattern_props.sv
`default_nettype none
module tpg_props #(
  parameter int DATA_W = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [DATA_W-1:0] adc_data,
  input wire logic spi_cs_n,
  input wire logic sdio_oe,
  input wire logic [DATA_W-1:0] dout_q,
  input wire logic test_active_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_reset_out: assert property (disable iff (1'b0) rst && ce |=> dout_q == 14'h0000 && !test_active_q)
    else $error("reset left output set");
  // format assumed at its twos complement default
  a_normal_pass: assert property ($past(ce) && !$past(rst) && !test_active_q |-> dout_q == $past(adc_data))
    else $error("sample not passed");
  a_ce_freeze: assert property (!ce |=> $stable(dout_q) && $stable(test_active_q))
    else $error("output moved with ce low");
  a_oe_idle: assert property (spi_cs_n [*6] |-> !sdio_oe)
    else $error("sdio driven outside frame");
  a_oe_framed: assert property ($rose(sdio_oe) |-> !$past(spi_cs_n, 8))
    else $error("sdio driven too early");
  a_check_alt: assert property (ce && test_active_q && dout_q == 14'h1555 && $past(dout_q) == 14'h2AAA
    |=> !ce || !test_active_q || dout_q == 14'h2AAA)
    else $error("checkerboard broken");
  a_toggle_alt: assert property (ce && test_active_q && dout_q == 14'h3FFF && $past(dout_q) == 14'h0000
    |=> !ce || !test_active_q || dout_q == 14'h0000)
    else $error("toggle broken");
  a_short_hold: assert property (ce && test_active_q && dout_q == 14'h1FFF && $past(dout_q) == 14'h1FFF
    |=> !test_active_q || dout_q == 14'h1FFF)
    else $error("short word moved");
endmodule // tpg_props
`default_nettype wire

//--- tb/tpg_capture_model.sv
`default_nettype none
module tpg_capture (
  input wire logic clk,
  input wire logic ce,
  input wire logic [13:0] word,
  output logic [13:0] hist [32]
);
  timeunit 1ns;
  timeprecision 1ps;
  // a window of recent words, so checks need not hit the exact launch cycle
  always @(posedge clk) begin
    if (ce) begin
      for (int i = 0; i < 31; i++) hist[i] <= hist[i+1];
      hist[31] <= word;
    end
  end
endmodule // tpg_capture
`default_nettype wire

//--- tb/test_adc_output_test_pattern_generator.sv
`default_nettype none
module test_adc_output_test_pattern_generator;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DATA_W = 14;
  logic clk, rst, ce, sclk, spi_cs_n, sdio_mst, sdio_out, sdio_oe, test_active_q;
  logic sdio_in;
  logic [13:0] adc_data, dout_q;
  logic [13:0] hist [32];
  logic [13:0] snap [32];
  logic [13:0] p [4];
  logic [7:0] rv;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  // two-way pin level from the port's sdio_oe enable; the master drives otherwise
  assign sdio_in = sdio_oe ? sdio_out : sdio_mst;
  tpg_test_pattern #(.DATA_W(DATA_W)) i_dut (.clk(clk), .rst(rst), .ce(ce), .adc_data(adc_data), .sclk(sclk),
    .spi_cs_n(spi_cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .dout_q(dout_q),
    .test_active_q(test_active_q));
  tpg_capture i_cap (.clk(clk), .ce(ce), .word(dout_q), .hist(hist));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // serial clock stands low between frames
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] sh;
    sh = {rd, a, wd};
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdio_mst = sh[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      if (i < 8) rv[i] = sdio_in;
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    spi_cs_n = 1'b1;
    sdio_mst = ~sdio_mst;
    repeat (8) @(negedge clk);
  endtask

  task automatic mode(input logic [7:0] m);
    xfer(1'b0, 15'h0550, m);
  endtask

  task automatic expect_seq(input logic [69:0] s, input string msg);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 28; k++)
      if ({hist[k], hist[k+1], hist[k+2], hist[k+3], hist[k+4]} === s) hit = 1'b1;
    check(hit, msg);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    xfer(1'b1, 15'h0550, 8'h00);
    check(rv === 8'h00, "mode reset value");
    xfer(1'b1, 15'h0600, 8'h00);
    check(rv === 8'h00, "unmapped read");
    xfer(1'b0, 15'h0558, 8'h5A);
    xfer(1'b1, 15'h0558, 8'h00);
    check(rv === 8'h5A, "user byte readback");
  endtask

  task automatic t_normal();
    adc_data = 14'h1234;
    repeat (8) @(negedge clk);
    expect_seq({5{14'h1234}}, "normal data");
    check(test_active_q === 1'b0, "flag in normal mode");
  endtask

  task automatic t_shorts();
    logic [13:0] w [3];
    w = '{14'h0000, 14'h1FFF, 14'h2000};
    adc_data = 14'h0ABC;
    for (int c = 1; c <= 3; c++) begin
      mode(8'(c));
      expect_seq({5{w[c-1]}}, "short word");
      check(test_active_q === 1'b1, "flag in test mode");
      mode(8'h00);
    end
  endtask

  task automatic t_alt();
    logic [13:0] w;
    mode(8'h04);
    expect_seq({14'h1555, 14'h2AAA, 14'h1555, 14'h2AAA, 14'h1555}, "checkerboard");
    mode(8'h00);
    mode(8'h07);
    expect_seq({14'h0000, 14'h3FFF, 14'h0000, 14'h3FFF, 14'h0000}, "toggle");
    ce = 1'b0;
    w = dout_q;
    repeat (3) @(negedge clk);
    check(dout_q === w, "ce low freeze");
    ce = 1'b1;
    mode(8'h00);
  endtask

  task automatic t_user();
    for (int i = 0; i < 8; i++) xfer(1'b0, 15'h0551 + 15'(i), 8'(8'h11 * (i + 1)));
    for (int n = 0; n < 4; n++) p[n] = 14'({8'(8'h11 * (2 * n + 2)), 8'(8'h11 * (2 * n + 1))} >> 2);
    mode(8'h08);
    expect_seq({p[0], p[1], p[2], p[3], p[0]}, "user repeat");
    mode(8'h00);
    mode(8'h88);
    expect_seq({p[0], p[1], p[2], p[3], 14'h0000}, "user single");
    mode(8'h00);
    mode(8'h0F);
    expect_seq({14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004}, "ramp");
    mode(8'h00);
  endtask

  task automatic t_pn();
    logic ok;
    for (int b = 0; b < 2; b++) begin
      mode(b ? 8'h26 : 8'h15);
      mode(b ? 8'h06 : 8'h05);
      snap = hist;
      check(hist[31] !== hist[30], "generator stuck");
      mode(b ? 8'h26 : 8'h15);
      mode(b ? 8'h06 : 8'h05);
      ok = 1'b1;
      for (int k = 0; k < 32; k++) if (snap[k] !== hist[k]) ok = 1'b0;
      check(ok, "reseed not repeatable");
      mode(8'h00);
    end
  endtask

  task automatic t_fmt();
    // park on the ramp, which no assertion watches, while the format moves
    mode(8'h0F);
    xfer(1'b0, 15'h0561, 8'h00);
    mode(8'h02);
    expect_seq({5{14'h3FFF}}, "offset binary short");
    mode(8'h07);
    expect_seq({14'h0000, 14'h3FFF, 14'h0000, 14'h3FFF, 14'h0000}, "toggle not raw");
    mode(8'h0F);
    xfer(1'b0, 15'h0561, 8'h02);
    xfer(1'b1, 15'h0561, 8'h00);
    check(rv === 8'h02, "format readback");
    mode(8'h01);
    expect_seq({5{14'h3000}}, "gray short");
    xfer(1'b0, 15'h0561, 8'h01);
    mode(8'h00);
  endtask
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sclk = 1'b0;
    spi_cs_n = 1'b1;
    sdio_mst = 1'b0;
    adc_data = 14'h0000;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_normal();
    t_shorts();
    t_alt();
    t_user();
    t_pn();
    t_fmt();
    summarize();
  end
endmodule // test_adc_output_test_pattern_generator

bind tpg_test_pattern tpg_props #(.DATA_W(DATA_W)) i_props (.clk(clk), .rst(rst), .ce(ce), .adc_data(adc_data),
  .spi_cs_n(spi_cs_n), .sdio_oe(sdio_oe), .dout_q(dout_q), .test_active_q(test_active_q));
`default_nettype wire
